// ### timer_io_map.svh
// Register map, field positions, reset values and event bits of the channel 3/4 I/O selection block
// How it works
// - Field 00xx: compare, pin starts low; 00 off, 01 low, 10 high on match.
// - Field 01xx: compare, pin starts high; 00 off, 01 low, 10 high on match.
// - Low bits 11 in compare mode toggle the pin at each match.
// - Field 1000: capture counter on rising edge of own pin.
// - Field 1001: capture counter on falling edge of own pin.
// - Field 101x: capture counter on both edges of own pin.
// - Channel 3 A and C field 11xx: capture on each channel 4 count step.
// - Channel 4 prescaler 000 makes the count-step capture source inert.
// - Buffer mode for register A: register C field yields no event.
// - Channel 4 A field 11xx: capture on channel 3 A match or capture.
// - Channel 3 register C field uses same encoding on its own pin C.
`ifndef TIMER_IO_MAP_SVH
`define TIMER_IO_MAP_SVH

`define OFS_CH3_IO_CTRL_HIGH 12'h000
`define OFS_CH3_IO_CTRL_LOW  12'h004
`define OFS_CH4_IO_CTRL      12'h008
`define OFS_CH3_MODE_REG     12'h00C
`define OFS_CH4_COUNTER_CTRL 12'h010
`define OFS_EVENT_STATUS     12'h014
`define OFS_EVENT_MASK       12'h018
`define OFS_PIN_STATE        12'h01C

`define RST_IO_CTRL          8'h00
`define RST_MODE             8'h00
`define RST_COUNTER_CTRL     8'h00
`define RST_MASK             8'h00

`define FLD_SEL_A_LSB        0
`define FLD_SEL_C_LSB        0
`define FLD_BUFFER_A_BIT     4
`define FLD_PRESCALE_LSB     0
`define PRESCALE_UNDIVIDED   3'h0

`define EVT_CH3_A            0
`define EVT_CH3_C            1
`define EVT_CH4_A            2
`define EVT_COUNT            3

`endif

// ### timer_io_pkg.sv
// Types shared by the channel 3/4 I/O selection block
package timer_io_pkg;
    typedef logic [3:0] io_sel_t;
    typedef enum logic [2:0]
    {
        BUS_IDLE  = 3'b001,
        BUS_WRITE = 3'b010,
        BUS_READ  = 3'b100
    } bus_state_e;
endpackage : timer_io_pkg

// ### io_select_unit.sv
// One general register's pin function: compare output or capture trigger
module io_select_unit
(
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    // Control
    input  wire timer_io_pkg::io_sel_t ioSel,
    input  wire logic                  inhibit,
    input  wire logic                  cascadeEvt,
    // Pin and match
    input  wire logic                  pinIn,
    input  wire logic                  compareMatch,
    // Results
    output logic                       pinOut,
    output logic                       pinOe,
    output logic                       captureEvt,
    output logic                       matchEvt
);
    logic pinPrev_ff;
    logic nxt_pinPrev;
    logic pinOut_ff;
    logic nxt_pinOut;
    logic pinOe_ff;
    logic nxt_pinOe;
    logic capture_ff;
    logic nxt_capture;
    logic match_ff;
    logic nxt_match;
    timer_io_pkg::io_sel_t selPrev_ff;
    logic isCompare;
    logic selChanged;

    assign isCompare  = ~ioSel[3] & ~inhibit;
    assign selChanged = ioSel != selPrev_ff;

    always_comb
    begin
        nxt_pinPrev = pinIn;
        nxt_pinOut  = pinOut_ff;
        nxt_pinOe   = 1'b0;
        nxt_capture = 1'b0;
        nxt_match   = 1'b0;
        if (isCompare)
        begin
            nxt_pinOe = ioSel[1:0] != 2'b00;
            // A match in the cycle of a select change still counts as an event
            nxt_match = compareMatch;
            if (selChanged)
            begin
                nxt_pinOut = ioSel[2];
            end
            else if (compareMatch)
            begin
                case (ioSel[1:0])
                    2'b01:   nxt_pinOut = 1'b0;
                    2'b10:   nxt_pinOut = 1'b1;
                    2'b11:   nxt_pinOut = ~pinOut_ff;
                    default: nxt_pinOut = pinOut_ff;
                endcase
            end
        end
        else if (!inhibit)
        begin
            casez (ioSel[2:0])
                3'b000:  nxt_capture = pinIn & ~pinPrev_ff;
                3'b001:  nxt_capture = ~pinIn & pinPrev_ff;
                3'b01?:  nxt_capture = pinIn ^ pinPrev_ff;
                default: nxt_capture = cascadeEvt;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            pinPrev_ff <= 1'b0;
            pinOut_ff  <= 1'b0;
            pinOe_ff   <= 1'b0;
            capture_ff <= 1'b0;
            match_ff   <= 1'b0;
            selPrev_ff <= 4'h0;
        end
        else
        begin
            pinPrev_ff <= nxt_pinPrev;
            pinOut_ff  <= nxt_pinOut;
            pinOe_ff   <= nxt_pinOe;
            capture_ff <= nxt_capture;
            match_ff   <= nxt_match;
            selPrev_ff <= ioSel;
        end
    end

    assign pinOut     = pinOut_ff;
    assign pinOe      = pinOe_ff;
    assign captureEvt = capture_ff;
    assign matchEvt   = match_ff;
endmodule : io_select_unit

// ### ahb_reg_slave.sv
// AHB-Lite slave front end: registers the address phase, always zero wait, OKAY
module ahb_reg_slave
(
    // AHB-Lite
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    // Decoded access
    output logic             wrEn,
    output logic             rdPhase,
    output logic [11:0]      accAddr
);
    timer_io_pkg::bus_state_e state_ff;
    timer_io_pkg::bus_state_e nxt_state;
    logic [11:0] addr_ff;
    logic [11:0] nxt_addr;

    always_comb
    begin
        nxt_state = timer_io_pkg::BUS_IDLE;
        nxt_addr  = addr_ff;
        if (hsel && htrans[1] && hready)
        begin
            nxt_addr  = {haddr[11:2], 2'b00};
            nxt_state = hwrite ? timer_io_pkg::BUS_WRITE : timer_io_pkg::BUS_READ;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_ff <= timer_io_pkg::BUS_IDLE;
            addr_ff  <= 12'h000;
        end
        else
        begin
            state_ff <= nxt_state;
            addr_ff  <= nxt_addr;
        end
    end

    always_comb
    begin
        wrEn    = 1'b0;
        rdPhase = 1'b0;
        case (state_ff)
            timer_io_pkg::BUS_WRITE: wrEn    = 1'b1;
            timer_io_pkg::BUS_READ:  rdPhase = 1'b1;
            default:                 wrEn    = 1'b0;
        endcase
    end

    assign accAddr = addr_ff;
endmodule : ahb_reg_slave

// ### timer_io_select_ch3_ch4.sv
// Top of the channel 3/4 I/O selection block with its register file
`include "timer_io_map.svh"
module timer_io_select_ch3_ch4
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Timer pins
    input  wire logic        ch3PinAIn,
    output logic             ch3PinAOut,
    output logic             ch3PinAOe,
    input  wire logic        ch3PinCIn,
    output logic             ch3PinCOut,
    output logic             ch3PinCOe,
    input  wire logic        ch4PinAIn,
    output logic             ch4PinAOut,
    output logic             ch4PinAOe,
    // Counter side
    input  wire logic        ch3MatchA,
    input  wire logic        ch3MatchC,
    input  wire logic        ch4MatchA,
    input  wire logic        ch4CountStep,
    output logic             ch3CaptureA,
    output logic             ch3CaptureC,
    output logic             ch4CaptureA,
    // Interrupt
    output logic             irq
);
    // ****************************************
    // Register file
    // ****************************************
    logic [7:0] ioHigh_ff;
    logic [7:0] nxt_ioHigh;
    logic [7:0] ioLow_ff;
    logic [7:0] nxt_ioLow;
    logic [7:0] io4_ff;
    logic [7:0] nxt_io4;
    logic [7:0] mode_ff;
    logic [7:0] nxt_mode;
    logic [7:0] cntCtrl_ff;
    logic [7:0] nxt_cntCtrl;
    logic [3:0] status_ff;
    logic [3:0] nxt_status;
    logic [3:0] mask_ff;
    logic [3:0] nxt_mask;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic irq_ff;
    logic nxt_irq;
    logic       wrEn;
    logic       rdPhase;
    logic [11:0] accAddr;
    logic [11:0] rdAddr;
    logic [3:0] evt;
    logic       bufferA;
    logic       countEvt;
    logic       capA3;
    logic       capC3;
    logic       capA4;
    logic       mtA3;
    logic       mtC3;
    logic       mtA4;
    logic       pA3o;
    logic       pA3e;
    logic       pC3o;
    logic       pC3e;
    logic       pA4o;
    logic       pA4e;

    ahb_reg_slave u_bus
    (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .hsel    (hsel),
        .haddr   (haddr),
        .htrans  (htrans),
        .hwrite  (hwrite),
        .hready  (hready),
        .wrEn    (wrEn),
        .rdPhase (rdPhase),
        .accAddr (accAddr)
    );

    // Read data follows the address being accepted, else the last one
    assign rdAddr   = (hsel && htrans[1] && hready) ? {haddr[11:2], 2'b00} : accAddr;
    // Buffer mode turns register C into register A's shadow
    assign bufferA  = mode_ff[`FLD_BUFFER_A_BIT];
    // With undivided count clock the step source is inert
    assign countEvt = ch4CountStep & (cntCtrl_ff[`FLD_PRESCALE_LSB +: 3] != `PRESCALE_UNDIVIDED);

    // ****************************************
    // Channel units
    // ****************************************
    io_select_unit u_ch3a
    (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .ioSel        (ioHigh_ff[`FLD_SEL_A_LSB +: 4]),
        .inhibit      (1'b0),
        .cascadeEvt   (countEvt),
        .pinIn        (ch3PinAIn),
        .compareMatch (ch3MatchA),
        .pinOut       (pA3o),
        .pinOe        (pA3e),
        .captureEvt   (capA3),
        .matchEvt     (mtA3)
    );

    io_select_unit u_ch3c
    (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .ioSel        (ioLow_ff[`FLD_SEL_C_LSB +: 4]),
        .inhibit      (bufferA),
        .cascadeEvt   (countEvt),
        .pinIn        (ch3PinCIn),
        .compareMatch (ch3MatchC),
        .pinOut       (pC3o),
        .pinOe        (pC3e),
        .captureEvt   (capC3),
        .matchEvt     (mtC3)
    );

    // Cascade takes channel 3 A match or capture; one cycle later than the source
    io_select_unit u_ch4a
    (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .ioSel        (io4_ff[`FLD_SEL_A_LSB +: 4]),
        .inhibit      (1'b0),
        .cascadeEvt   (capA3 | mtA3),
        .pinIn        (ch4PinAIn),
        .compareMatch (ch4MatchA),
        .pinOut       (pA4o),
        .pinOe        (pA4e),
        .captureEvt   (capA4),
        .matchEvt     (mtA4)
    );

    assign evt[`EVT_CH3_A] = capA3 | mtA3;
    assign evt[`EVT_CH3_C] = capC3 | mtC3;
    assign evt[`EVT_CH4_A] = capA4 | mtA4;
    assign evt[`EVT_COUNT] = countEvt;

    // ****************************************
    // Register write, status and read
    // ****************************************
    always_comb
    begin
        nxt_ioHigh  = ioHigh_ff;
        nxt_ioLow   = ioLow_ff;
        nxt_io4     = io4_ff;
        nxt_mode    = mode_ff;
        nxt_cntCtrl = cntCtrl_ff;
        nxt_mask    = mask_ff;
        nxt_status  = status_ff;
        if (wrEn)
        begin
            case (accAddr)
                `OFS_CH3_IO_CTRL_HIGH: nxt_ioHigh  = hwdata[7:0];
                `OFS_CH3_IO_CTRL_LOW:  nxt_ioLow   = hwdata[7:0];
                `OFS_CH4_IO_CTRL:      nxt_io4     = hwdata[7:0];
                `OFS_CH3_MODE_REG:     nxt_mode    = hwdata[7:0];
                `OFS_CH4_COUNTER_CTRL: nxt_cntCtrl = hwdata[7:0];
                `OFS_EVENT_MASK:       nxt_mask    = hwdata[3:0];
                `OFS_EVENT_STATUS:     nxt_status  = status_ff & ~hwdata[3:0];
                default:               nxt_mask    = mask_ff;
            endcase
        end
        // A new event wins over a clear in the same cycle
        nxt_status = nxt_status | evt;
        nxt_irq    = |(nxt_status & nxt_mask);
        nxt_rdata  = 32'h0000_0000;
        case (rdAddr)
            `OFS_CH3_IO_CTRL_HIGH: nxt_rdata[7:0] = nxt_ioHigh;
            `OFS_CH3_IO_CTRL_LOW:  nxt_rdata[7:0] = nxt_ioLow;
            `OFS_CH4_IO_CTRL:      nxt_rdata[7:0] = nxt_io4;
            `OFS_CH3_MODE_REG:     nxt_rdata[7:0] = nxt_mode;
            `OFS_CH4_COUNTER_CTRL: nxt_rdata[7:0] = nxt_cntCtrl;
            `OFS_EVENT_STATUS:     nxt_rdata[3:0] = nxt_status;
            `OFS_EVENT_MASK:       nxt_rdata[3:0] = nxt_mask;
            `OFS_PIN_STATE:        nxt_rdata[5:0] = {pA4e, pA4o, pC3e, pC3o, pA3e, pA3o};
            default:               nxt_rdata      = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ioHigh_ff  <= `RST_IO_CTRL;
            ioLow_ff   <= `RST_IO_CTRL;
            io4_ff     <= `RST_IO_CTRL;
            mode_ff    <= `RST_MODE;
            cntCtrl_ff <= `RST_COUNTER_CTRL;
            mask_ff    <= 4'h0;
            status_ff  <= 4'h0;
            rdata_ff   <= 32'h0000_0000;
            irq_ff     <= 1'b0;
        end
        else
        begin
            ioHigh_ff  <= nxt_ioHigh;
            ioLow_ff   <= nxt_ioLow;
            io4_ff     <= nxt_io4;
            mode_ff    <= nxt_mode;
            cntCtrl_ff <= nxt_cntCtrl;
            mask_ff    <= nxt_mask;
            status_ff  <= nxt_status;
            rdata_ff   <= nxt_rdata;
            irq_ff     <= nxt_irq;
        end
    end

    // Outputs; unit outputs are already flip-flops
    assign hrdata      = rdata_ff;
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign irq         = irq_ff;
    assign ch3PinAOut  = pA3o;
    assign ch3PinAOe   = pA3e;
    assign ch3PinCOut  = pC3o;
    assign ch3PinCOe   = pC3e;
    assign ch4PinAOut  = pA4o;
    assign ch4PinAOe   = pA4e;
    assign ch3CaptureA = capA3;
    assign ch3CaptureC = capC3;
    assign ch4CaptureA = capA4;
endmodule : timer_io_select_ch3_ch4

// ### timer_io_select_props.sv
// Checker of pin functions and capture sources of the channel 3/4 I/O block
`include "timer_io_map.svh"
module timer_io_select_props
(
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // Bus
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Pins and events
    input wire logic        ch3PinAIn,
    input wire logic        ch3PinAOut,
    input wire logic        ch3PinAOe,
    input wire logic        ch3PinCOut,
    input wire logic        ch4PinAIn,
    input wire logic        ch3MatchA,
    input wire logic        ch3MatchC,
    input wire logic        ch4CountStep,
    input wire logic        ch3CaptureA,
    input wire logic        ch3CaptureC,
    input wire logic        ch4CaptureA
);
    // ****************************************
    // Shadow of the select fields
    // ****************************************
    logic        wrPend_ff;
    logic [11:0] wrAddr_ff;
    logic [3:0]  selA_ff, selC_ff, sel4_ff, age_ff;
    logic [2:0]  presc_ff;
    logic        bufA_ff;
    logic        ok;
    always_ff @(posedge mclk)
    begin
        wrPend_ff <= rst_n && hsel && htrans[1] && hready && hwrite;
        wrAddr_ff <= haddr;
        age_ff    <= (!rst_n || wrPend_ff) ? 4'h0 : age_ff + 4'(age_ff != 4'hF);
        if (!rst_n || wrPend_ff && wrAddr_ff == `OFS_CH3_IO_CTRL_HIGH)
            selA_ff <= hwdata[3:0] & {4{rst_n}};
        if (!rst_n || wrPend_ff && wrAddr_ff == `OFS_CH3_IO_CTRL_LOW)
            selC_ff <= hwdata[3:0] & {4{rst_n}};
        if (!rst_n || wrPend_ff && wrAddr_ff == `OFS_CH4_IO_CTRL)
            sel4_ff <= hwdata[3:0] & {4{rst_n}};
        if (!rst_n || wrPend_ff && wrAddr_ff == `OFS_CH3_MODE_REG)
            bufA_ff <= hwdata[4] & rst_n;
        if (!rst_n || wrPend_ff && wrAddr_ff == `OFS_CH4_COUNTER_CTRL)
            presc_ff <= hwdata[2:0] & {3{rst_n}};
    end
    // Settled settings only: a write in flight makes the expected pin level ambiguous
    assign ok = age_ff > 4'h1 && !wrPend_ff;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ****************************************
    // Properties
    // ****************************************
    chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready or not OKAY");
    chk_oe_disabled: assert property (ok && !selA_ff[3] && selA_ff[1:0] == 2'b00 |-> !ch3PinAOe)
        else $error("pin A driven while output disabled");
    chk_init_level: assert property (ok && age_ff == 4'h2 && !selA_ff[3] && selA_ff[1:0] != 2'b00
        && selA_ff != $past(selA_ff, 3)
        && !$past(ch3MatchA) && !$past(ch3MatchA, 2) && !$past(ch3MatchA, 3) |-> ch3PinAOut == selA_ff[2])
        else $error("pin A initial level wrong");
    chk_match_low: assert property (ok && selA_ff[3] == 1'b0 && selA_ff[1:0] == 2'b01 && ch3MatchA
        |=> !ch3PinAOut) else $error("pin A not low after match");
    chk_match_high: assert property (ok && selA_ff[3] == 1'b0 && selA_ff[1:0] == 2'b10 && ch3MatchA
        |=> ch3PinAOut && ch3PinAOe) else $error("pin A not high after match");
    chk_match_toggle: assert property (ok && selA_ff[3] == 1'b0 && selA_ff[1:0] == 2'b11 && ch3MatchA
        |=> ch3PinAOut != $past(ch3PinAOut)) else $error("pin A did not toggle");
    chk_rise_capt: assert property (ok && selA_ff == 4'h8 && $rose(ch3PinAIn) |-> ##[1:3] ch3CaptureA)
        else $error("no capture on rising edge");
    chk_fall_capt: assert property (ok && selA_ff == 4'h9 && $fell(ch3PinAIn) |-> ##[1:3] ch3CaptureA)
        else $error("no capture on falling edge");
    chk_both_capt: assert property (ok && sel4_ff[3:1] == 3'b101 && $changed(ch4PinAIn)
        |-> ##[1:3] ch4CaptureA) else $error("no capture on pin change");
    chk_step_capt: assert property (ok && selA_ff[3:2] == 2'b11 && presc_ff != 3'h0 && ch4CountStep
        |-> ##[1:3] ch3CaptureA) else $error("no capture on count step");
    chk_step_inert: assert property (ok && selA_ff[3:2] == 2'b11 && presc_ff == 3'h0 |-> !ch3CaptureA)
        else $error("capture with undivided count clock");
    chk_buf_silent: assert property (ok && bufA_ff |-> !ch3CaptureC)
        else $error("register C active in buffer mode");
    chk_casc_ch4: assert property (ok && sel4_ff[3:2] == 2'b11 && ch3CaptureA |-> ##[1:3] ch4CaptureA)
        else $error("channel 4 missed channel 3 event");
    chk_c_match: assert property (ok && !bufA_ff && selC_ff == 4'h1 && ch3MatchC |=> !ch3PinCOut)
        else $error("pin C not low after match");
    cov_step: cover property (ch3CaptureA && selA_ff[3:2] == 2'b11);
    cov_casc: cover property (ch4CaptureA && sel4_ff[3:2] == 2'b11);
    cov_buf: cover property (bufA_ff && ch3MatchC);
endmodule : timer_io_select_props

bind timer_io_select_ch3_ch4 timer_io_select_props u_timer_io_select_props (.mclk, .rst_n, .hsel, .haddr,
    .htrans, .hwrite, .hready, .hwdata, .hreadyout, .hresp, .ch3PinAIn, .ch3PinAOut, .ch3PinAOe, .ch3PinCOut,
    .ch4PinAIn, .ch3MatchA, .ch3MatchC, .ch4CountStep, .ch3CaptureA, .ch3CaptureC, .ch4CaptureA);

// ### timer_far_side.sv
// Model of the timer pins and neighbouring counters facing the I/O block
module timer_far_side
(
    // Clock
    input wire logic mclk,
    // Pin levels
    output logic     ch3PinAIn,
    output logic     ch3PinCIn,
    output logic     ch4PinAIn,
    // Counter events, one cycle each
    output logic     ch3MatchA,
    output logic     ch3MatchC,
    output logic     ch4MatchA,
    output logic     ch4CountStep
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] pinLvl = 3'h0;
    logic [3:0] evt    = 4'h0;
    assign {ch4PinAIn, ch3PinCIn, ch3PinAIn} = pinLvl;
    assign {ch4CountStep, ch4MatchA, ch3MatchC, ch3MatchA} = evt;
    // Callers enter right after a rising edge; a slow counter idles first
    task automatic pulse(input int idx, input int gap);
        repeat (gap) @(posedge mclk);
        evt <= 4'h1 << idx;
        @(posedge mclk);
        evt <= 4'h0;
        repeat (2) @(posedge mclk);
    endtask : pulse
    task automatic setPin(input int idx, input logic lvl);
        pinLvl <= (pinLvl & ~(3'h1 << idx)) | (3'(lvl) << idx);
        @(posedge mclk);
    endtask : setPin
endmodule : timer_far_side

// ### testbench.sv
// Self-checking testbench of the channel 3/4 I/O selection block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Signals, clock and instances
    // ****************************************
    logic        mclk   = 1'b0;
    logic        rst_n  = 1'b0;
    logic        hsel   = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize  = 3'h2;
    logic [11:0] haddr  = 12'h000;
    logic [31:0] hwdata = 32'h0, hrdata, rdv, v;
    logic        hreadyout, hresp, irq, ch3CaptureA, ch3CaptureC, ch4CaptureA;
    logic        ch3PinAOut, ch3PinAOe, ch3PinCOut, ch3PinCOe, ch4PinAOut, ch4PinAOe;
    logic        ch3PinAIn, ch3PinCIn, ch4PinAIn, ch3MatchA, ch3MatchC, ch4MatchA, ch4CountStep;
    int          errors   = 0;
    int          compares = 0;
    int          seed     = 85748;
    int          capCnt[3] = '{0, 0, 0};
    wire  [5:0]  pins = {ch4PinAOe, ch4PinAOut, ch3PinCOe, ch3PinCOut, ch3PinAOe, ch3PinAOut};
    always #2 mclk = ~mclk;
    timer_io_select_ch3_ch4 u_timer_io_select_ch3_ch4 (.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .ch3PinAIn, .ch3PinAOut, .ch3PinAOe,
        .ch3PinCIn, .ch3PinCOut, .ch3PinCOe, .ch4PinAIn, .ch4PinAOut, .ch4PinAOe, .ch3MatchA, .ch3MatchC,
        .ch4MatchA, .ch4CountStep, .ch3CaptureA, .ch3CaptureC, .ch4CaptureA, .irq);
    timer_far_side u_timer_far_side (.mclk, .ch3PinAIn, .ch3PinCIn, .ch4PinAIn, .ch3MatchA, .ch3MatchC,
        .ch4MatchA, .ch4CountStep);
    always @(posedge mclk)
    begin
        capCnt[0] += ch3CaptureA === 1'b1;
        capCnt[1] += ch3CaptureC === 1'b1;
        capCnt[2] += ch4CaptureA === 1'b1;
    end
    // ****************************************
    // Bus cycles and checks
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // One single word transfer; read data lands in rdv
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        @(posedge mclk);
        while (hreadyout !== 1'b1)
            @(posedge mclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge mclk);
        while (hreadyout !== 1'b1)
            @(posedge mclk);
        rdv = hrdata;
    endtask : bus
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (20000) @(posedge mclk);
        errors++;
        tally_and_finish();
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial
    begin
        int n;
        logic [1:0] g;
        logic oe;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        for (int i = 0; i < 9; i++)
        begin
            bus(1'b1, 12'h020, 32'hF);
            bus(1'b0, 12'(i * 4), 32'h0);
            check(rdv, 32'h0);
        end
        for (int i = 0; i < 3; i++)
        begin
            v = 32'($unsigned($random(seed)) % 16);
            bus(1'b1, 12'(i * 4), v);
            bus(1'b0, 12'(i * 4), 32'h0);
            check(rdv, v);
        end
        for (int ch = 0; ch < 3; ch++)
            for (int s = 0; s < 8; s++)
            begin
                bus(1'b1, 12'(ch * 4), 32'(s));
                repeat (3) @(posedge mclk);
                oe = s[1:0] != 2'b00;
                g = pins[ch * 2 +: 2];
                check({g[1], g[1] & g[0]}, {oe, oe & s[2]});
                for (int k = 1; k < 3; k++)
                begin
                    u_timer_far_side.pulse(ch, $unsigned($random(seed)) % 3);
                    g = pins[ch * 2 +: 2];
                    check({g[1], g[1] & g[0]}, {oe, oe & (s[1] ? (s[0] ? s[2] ^ k[0] : 1'b1) : 1'b0)});
                end
            end
        bus(1'b0, 12'h01C, 32'h0);
        check(rdv, 32'h3F);
        bus(1'b0, 12'h014, 32'h0);
        check(rdv, 32'h7);
        bus(1'b1, 12'h018, 32'h1);
        repeat (2) @(posedge mclk);
        check(irq, 1'b1);
        bus(1'b1, 12'h018, 32'h0);
        repeat (2) @(posedge mclk);
        check(irq, 1'b0);
        bus(1'b1, 12'h014, 32'h7);
        bus(1'b1, 12'h018, 32'h1);
        bus(1'b0, 12'h014, 32'h0);
        check(rdv, 32'h0);
        check(irq, 1'b0);
        for (int ch = 0; ch < 3; ch++)
            for (int s = 8; s < 11; s++)
            begin
                bus(1'b1, 12'(ch * 4), 32'(s));
                capCnt = '{0, 0, 0};
                repeat (2) @(posedge mclk);
                u_timer_far_side.setPin(ch, 1'b1);
                repeat (4) @(posedge mclk);
                check(capCnt[ch], s != 9);
                u_timer_far_side.setPin(ch, 1'b0);
                repeat (4) @(posedge mclk);
                check(capCnt[ch], s == 10 ? 2 : 1);
            end
        bus(1'b1, 12'h000, 32'hC);
        bus(1'b1, 12'h004, 32'hF);
        bus(1'b1, 12'h008, 32'hC);
        for (int p = 0; p < 2; p++)
        begin
            bus(1'b1, 12'h010, 32'(p * ($unsigned($random(seed)) % 7 + 1)));
            n = $unsigned($random(seed)) % 4 + 2;
            capCnt = '{0, 0, 0};
            repeat (n) u_timer_far_side.pulse(3, $unsigned($random(seed)) % 3);
            repeat (4) @(posedge mclk);
            check(capCnt[0], p * n);
            check(capCnt[1], p * n);
            check(capCnt[2], p * n);
        end
        bus(1'b0, 12'h014, 32'h0);
        check(rdv, 32'hF);
        bus(1'b1, 12'h000, 32'h1);
        capCnt = '{0, 0, 0};
        u_timer_far_side.pulse(0, 0);
        repeat (3) @(posedge mclk);
        check(capCnt[2], 1);
        bus(1'b1, 12'h00C, 32'h10);
        bus(1'b1, 12'h004, 32'h8);
        bus(1'b1, 12'h014, 32'hF);
        capCnt = '{0, 0, 0};
        u_timer_far_side.setPin(1, 1'b1);
        u_timer_far_side.pulse(1, 1);
        repeat (4) @(posedge mclk);
        check(capCnt[1], 0);
        bus(1'b0, 12'h014, 32'h0);
        check(rdv, 32'h0);
        tally_and_finish();
    end
endmodule : testbench
